// ---- include/atw_params.svh ----
// Behaviour
// - Burst off: power follows converter enable only.
// - Burst on, enabled: converter stays powered.
// - Burst on, disabled: power up per start.
// - Tracking mode codes 01,10,11; 00 reserved.
// - Post-track 2/4/8/16 SAR plus two base.
// - Compare every new result against limits.
// - Window flag readable and drives request.
// - Two 16-bit limits from byte pairs.
// - Inside/outside chosen by limit ordering.
// - Inside: strictly between both limits.
// - Source select: pin clear, supply set.
// - Level select: 1.5 V clear, 2.2 V set.
// - Bias reads one when any user on.
// - Temperature sensor enable switches sensor.
// - Buffer enable drives reference onto pin.
// - Zero-tempco bias forced on when set.
// - Top two reference bits read zero.
// - Burst enable selects self-timed operation.
// - Converter enable: active or shutdown.
// - Window flag sticky until software clears.
`ifndef ATW_PARAMS_SVH
`define ATW_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define ATW_ADDR_TK    8'hba
`define ATW_ADDR_GTH   8'hc4
`define ATW_ADDR_GTL   8'hc3
`define ATW_ADDR_LTL   8'hc5
`define ATW_ADDR_LTH   8'hc6
`define ATW_ADDR_REF   8'hd1
`define ATW_ADDR_CTL   8'he8

// ----------------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------------
`define ATW_RST_TK     8'hff
`define ATW_RST_LIMIT  8'h00
`define ATW_RST_GT     8'hff
`define ATW_RST_REF    8'h00
`define ATW_RST_CTL    8'h00
`define ATW_REF_MASK   8'h3f
`define ATW_CTL_EN     7
`define ATW_CTL_BURST  6
`define ATW_CTL_WINT   3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ATW_CLK_NS     100
`define ATW_PWR_STEP_NS 200
`define ATW_PWR_STEP_CYC ((`ATW_PWR_STEP_NS + `ATW_CLK_NS - 1) / `ATW_CLK_NS)
`define ATW_EXTRA_BASE 2

`endif

// ---- include/atw_pkg.sv ----
package atw_pkg;
   typedef enum logic [1:0] {
      ATW_TM_RSVD = 2'b00,
      ATW_TM_POST = 2'b01,
      ATW_TM_PRE  = 2'b10,
      ATW_TM_DUAL = 2'b11
   } atw_track_e;
   typedef enum logic [3:0] {
      ATW_PS_OFF  = 4'b0001,
      ATW_PS_ON   = 4'b0010,
      ATW_PS_WAKE = 4'b0100,
      ATW_PS_LOW  = 4'b1000
   } atw_pwr_e;
endpackage : atw_pkg

// ---- verilog/atw_window_cmp.sv ----
`include "atw_params.svh"
module atw_window_cmp
   import atw_pkg::*;
(
   input  wire logic        clk,        // System clock.
   input  wire logic        rst_n,      // Asynchronous reset, active low.
   input  wire logic        res_valid,  // New result written this cycle.
   input  wire logic [15:0] result,     // Result word as justified.
   input  wire logic [15:0] gt_limit,   // Greater-than limit.
   input  wire logic [15:0] lt_limit,   // Less-than limit.
   output logic             hit         // One-cycle match pulse.
);
   logic inside_mode;
   logic match;

   assign inside_mode = lt_limit > gt_limit;
   always_comb begin
      if (inside_mode) begin
         match = (result > gt_limit) && (result < lt_limit);
      end else begin
         match = (result > gt_limit) || (result < lt_limit);
      end
   end

   // Evaluated only when the output registers update, so a stale result never re-fires.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hit <= 1'b0;
      end else begin
         hit <= res_valid && match;
      end
   end

   inside_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
      res_valid && lt_limit > gt_limit && (result <= gt_limit || result >= lt_limit) |=> !hit)
      else $error("inside window fired outside limits");
   outside_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
      res_valid && lt_limit <= gt_limit && result > gt_limit |=> hit)
      else $error("outside window missed above limit");
endmodule : atw_window_cmp

// ---- verilog/atw_power_timer.sv ----
`include "atw_params.svh"
module atw_power_timer
   import atw_pkg::*;
(
   input  wire logic       clk,         // System clock.
   input  wire logic       rst_n,       // Asynchronous reset, active low.
   input  wire logic       conv_en,     // Converter enable.
   input  wire logic       burst_en,    // Burst mode enable.
   input  wire logic       conv_start,  // Convert start pulse.
   input  wire logic [3:0] pwr_time,    // Burst power-up field.
   output logic            powered,     // Converter powered.
   output logic            ready        // Power-up wait done pulse.
);
   atw_pwr_e   state_r;
   atw_pwr_e   state_nxt;
   logic [6:0] cnt_r;
   logic [6:0] wait_cyc;

   assign wait_cyc = 7'(({3'b000, pwr_time} + 7'd1) * 7'(`ATW_PWR_STEP_CYC));

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ATW_PS_OFF, ATW_PS_ON, ATW_PS_LOW: begin
            if (!burst_en) begin
               state_nxt = conv_en ? ATW_PS_ON : ATW_PS_OFF;
            end else if (conv_en) begin
               state_nxt = ATW_PS_ON;
            end else if (conv_start) begin
               state_nxt = ATW_PS_WAKE;
            end else begin
               state_nxt = ATW_PS_LOW;
            end
         end
         ATW_PS_WAKE: begin
            if (!burst_en || conv_en) begin
               state_nxt = conv_en ? ATW_PS_ON : ATW_PS_OFF;
            end else if (cnt_r == 7'd1) begin
               state_nxt = ATW_PS_LOW;
            end
         end
         default: state_nxt = ATW_PS_OFF;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ATW_PS_OFF;
         cnt_r   <= 7'd0;
         powered <= 1'b0;
         ready   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= (state_nxt == ATW_PS_WAKE && state_r != ATW_PS_WAKE) ? wait_cyc
                    : (cnt_r != 7'd0 ? cnt_r - 7'd1 : 7'd0);
         powered <= state_nxt == ATW_PS_ON || state_nxt == ATW_PS_WAKE;
         ready   <= state_r == ATW_PS_WAKE && state_nxt == ATW_PS_LOW;
      end
   end

   stay_on_a: assert property (@(posedge clk) disable iff (!rst_n)
      burst_en && conv_en ##1 burst_en && conv_en |=> powered)
      else $error("burst with enable dropped power");
   off_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      !burst_en && !conv_en |=> !powered)
      else $error("power not following enable");
   wake_time_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_r == ATW_PS_LOW && burst_en && !conv_en && conv_start && pwr_time == 4'd0
      ##1 (burst_en && !conv_en) [*2] |=> ready)
      else $error("power-up wait not 200 ns");
   wake_c: cover property (@(posedge clk) disable iff (!rst_n) ready);
endmodule : atw_power_timer

// ---- verilog/atw_top.sv ----
`include "atw_params.svh"
module atw_top
   import atw_pkg::*;
(
   input  wire logic        clk,            // System clock, 10 MHz.
   input  wire logic        rst_n,          // Asynchronous reset, active low.
   input  wire logic [7:0]  sfr_addr,       // Register address.
   input  wire logic [7:0]  sfr_wdata,      // Write data.
   input  wire logic        sfr_wr,         // Write strobe.
   input  wire logic        sfr_rd,         // Read strobe.
   output logic      [7:0]  sfr_rdata,      // Read data, registered.
   input  wire logic        conv_start,     // Convert start pulse.
   input  wire logic        res_valid,      // Result registers update.
   input  wire logic [15:0] result,         // Result word.
   input  wire logic        osc_on,         // Internal oscillators on.
   output logic             conv_powered,   // Converter powered.
   output logic             conv_ready,     // Burst power-up done.
   output logic [1:0]       tracking_mode,  // Tracking mode code.
   output logic [4:0]       post_track_sar, // Post-track SAR periods.
   output logic [1:0]       post_track_base,// Extra base-clock periods.
   output logic             window_irq,     // Window flag request.
   output logic             ref_vdd_sel,    // Reference from supply.
   output logic             ref_high_lvl,   // Reference at 2.2 V.
   output logic             temp_sensor_on, // Temperature sensor on.
   output logic             bias_on,        // Analog bias on.
   output logic             ref_buf_on,     // Reference buffer drives pin.
   output logic             ztc_forced      // Zero-tempco bias forced.
);
   // ------------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------------
   logic [7:0] tk_r;
   logic [7:0] gth_r;
   logic [7:0] gtl_r;
   logic [7:0] lth_r;
   logic [7:0] ltl_r;
   logic [5:0] ref_r;
   logic [7:0] ctl_r;
   logic       hit;
   logic       powered;
   logic       ready;
   logic       wr_ctl;

   assign wr_ctl = sfr_wr && sfr_addr == `ATW_ADDR_CTL;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tk_r  <= `ATW_RST_TK;
         gth_r <= `ATW_RST_GT;
         gtl_r <= `ATW_RST_GT;
         lth_r <= `ATW_RST_LIMIT;
         ltl_r <= `ATW_RST_LIMIT;
         ref_r <= 6'(`ATW_RST_REF);
      end else if (sfr_wr) begin
         case (sfr_addr)
            `ATW_ADDR_TK:  tk_r  <= sfr_wdata;
            `ATW_ADDR_GTH: gth_r <= sfr_wdata;
            `ATW_ADDR_GTL: gtl_r <= sfr_wdata;
            `ATW_ADDR_LTH: lth_r <= sfr_wdata;
            `ATW_ADDR_LTL: ltl_r <= sfr_wdata;
            `ATW_ADDR_REF: ref_r <= sfr_wdata[5:0];
            default: ;
         endcase
      end
   end

   // The window flag is sticky: a match in the clearing cycle wins.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_r <= `ATW_RST_CTL;
      end else begin
         if (wr_ctl) begin
            ctl_r <= sfr_wdata;
         end
         if (hit) begin
            ctl_r[`ATW_CTL_WINT] <= 1'b1;
         end else if (wr_ctl) begin
            ctl_r[`ATW_CTL_WINT] <= sfr_wdata[`ATW_CTL_WINT] & ctl_r[`ATW_CTL_WINT];
         end
      end
   end

   // ------------------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         case (sfr_addr)
            `ATW_ADDR_TK:  sfr_rdata <= tk_r;
            `ATW_ADDR_GTH: sfr_rdata <= gth_r;
            `ATW_ADDR_GTL: sfr_rdata <= gtl_r;
            `ATW_ADDR_LTH: sfr_rdata <= lth_r;
            `ATW_ADDR_LTL: sfr_rdata <= ltl_r;
            `ATW_ADDR_REF: sfr_rdata <= {2'b00, ref_r[5:2], ref_r[1] | bias_need(), ref_r[0]};
            `ATW_ADDR_CTL: sfr_rdata <= ctl_r;
            default:       sfr_rdata <= 8'h00;
         endcase
      end
   end

   function automatic logic bias_need();
      bias_need = ctl_r[`ATW_CTL_EN] | ref_r[2] | osc_on;
   endfunction : bias_need

   // ------------------------------------------------------------------------
   // Submodules
   // ------------------------------------------------------------------------
   atw_power_timer u_pwr (
      .clk        (clk),
      .rst_n      (rst_n),
      .conv_en    (ctl_r[`ATW_CTL_EN]),
      .burst_en   (ctl_r[`ATW_CTL_BURST]),
      .conv_start (conv_start),
      .pwr_time   (tk_r[7:4]),
      .powered    (powered),
      .ready      (ready)
   );

   atw_window_cmp u_win (
      .clk       (clk),
      .rst_n     (rst_n),
      .res_valid (res_valid),
      .result    (result),
      .gt_limit  ({gth_r, gtl_r}),
      .lt_limit  ({lth_r, ltl_r}),
      .hit       (hit)
   );

   // ------------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_powered    <= 1'b0;
         conv_ready      <= 1'b0;
         tracking_mode   <= ATW_TM_DUAL;
         post_track_sar  <= 5'd16;
         post_track_base <= 2'd`ATW_EXTRA_BASE;
         window_irq      <= 1'b0;
      end else begin
         conv_powered    <= powered;
         conv_ready      <= ready;
         tracking_mode   <= tk_r[3:2];
         post_track_sar  <= 5'(5'd2 << tk_r[1:0]);
         post_track_base <= 2'd`ATW_EXTRA_BASE;
         window_irq      <= ctl_r[`ATW_CTL_WINT];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_vdd_sel    <= 1'b0;
         ref_high_lvl   <= 1'b0;
         temp_sensor_on <= 1'b0;
         bias_on        <= 1'b0;
         ref_buf_on     <= 1'b0;
         ztc_forced     <= 1'b0;
      end else begin
         ref_vdd_sel    <= ref_r[3];
         ref_high_lvl   <= ref_r[4];
         temp_sensor_on <= ref_r[2];
         bias_on        <= ref_r[1] | bias_need();
         ref_buf_on     <= ref_r[0];
         ztc_forced     <= ref_r[5];
      end
   end

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
      ctl_r[`ATW_CTL_WINT] && !wr_ctl |=> ctl_r[`ATW_CTL_WINT])
      else $error("window flag cleared by hardware");
   flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
      hit |=> ctl_r[`ATW_CTL_WINT] ##1 window_irq)
      else $error("match did not raise flag");
   ref_top_a: assert property (@(posedge clk) disable iff (!rst_n)
      sfr_rd && sfr_addr == `ATW_ADDR_REF |=> sfr_rdata[7:6] == 2'b00)
      else $error("reserved reference bits nonzero");
   bias_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      ctl_r[`ATW_CTL_EN] |=> bias_on)
      else $error("bias not on with converter");
   track_a: assert property (@(posedge clk) disable iff (!rst_n)
      tk_r[1:0] == 2'b11 |=> post_track_sar == 5'd16)
      else $error("post-track length wrong");
   ref_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 ref_vdd_sel == $past(ref_r[3]))
      else $error("reference source not following register");
   hit_c: cover property (@(posedge clk) disable iff (!rst_n) hit);
   clear_c: cover property (@(posedge clk) disable iff (!rst_n)
      ctl_r[`ATW_CTL_WINT] ##1 !ctl_r[`ATW_CTL_WINT]);
   burst_c: cover property (@(posedge clk) disable iff (!rst_n)
      ctl_r[`ATW_CTL_BURST] && !ctl_r[`ATW_CTL_EN] && conv_start);
endmodule : atw_top

// ---- tb/tb_top.sv ----
`include "atw_params.svh"
`define TB_CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_mismatch++; \
   $display("unexpected %s expected %h seen %h", nm, e, s); end end
module tb_top
   import atw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {string nm; logic [7:0] e;} atw_note_s;
   logic        clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, conv_start = 0, res_valid = 0, osc_on = 0;
   logic [7:0]  sfr_addr = 0, sfr_wdata = 0, sfr_rdata, d;
   logic [15:0] result = 0, gt, lt, r;
   logic [1:0]  tracking_mode, post_track_base;
   logic [4:0]  post_track_sar;
   logic        conv_powered, conv_ready, window_irq, ref_vdd_sel, ref_high_lvl;
   logic        temp_sensor_on, bias_on, ref_buf_on, ztc_forced, o, b, h;
   int          n_mismatch = 0, checked = 0, seed = 40, n, lo;
   atw_note_s   q[$];
   atw_note_s   nt;

   atw_top dut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .conv_start(conv_start), .res_valid(res_valid),
      .result(result), .osc_on(osc_on), .conv_powered(conv_powered), .conv_ready(conv_ready),
      .tracking_mode(tracking_mode), .post_track_sar(post_track_sar), .post_track_base(post_track_base),
      .window_irq(window_irq), .ref_vdd_sel(ref_vdd_sel), .ref_high_lvl(ref_high_lvl),
      .temp_sensor_on(temp_sensor_on), .bias_on(bias_on), .ref_buf_on(ref_buf_on), .ztc_forced(ztc_forced));

   always #50 clk = ~clk;

   // ---------------------------------------------------------------------
   // Register access and read-data monitor
   // ---------------------------------------------------------------------
   // Each access is followed by an idle edge so no strobe is set twice in one step.
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      sfr_addr = a; sfr_wdata = v; sfr_wr = 1;
      @(posedge clk); #1 sfr_wr = 0; sfr_wdata = ~v;
      @(posedge clk); #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      q.push_back('{nm, e});
      sfr_addr = a; sfr_rd = 1;
      @(posedge clk); #1 sfr_rd = 0;
      @(posedge clk); #1;
   endtask : rd

   always @(posedge clk) begin
      if (sfr_rd === 1'b1) begin
         #2 nt = q.pop_front();
         `TB_CHK(nt.nm, nt.e, sfr_rdata)
      end
   end

   // ---------------------------------------------------------------------
   // Window helpers
   // ---------------------------------------------------------------------
   function automatic logic exp_hit(input logic [15:0] v, input logic [15:0] g, input logic [15:0] l);
      exp_hit = (l > g) ? (v > g && v < l) : (v > g || v < l);
   endfunction : exp_hit

   task automatic setlim(input logic [15:0] g, input logic [15:0] l);
      gt = g; lt = l;
      wr(`ATW_ADDR_GTH, g[15:8]); wr(`ATW_ADDR_GTL, g[7:0]);
      wr(`ATW_ADDR_LTH, l[15:8]); wr(`ATW_ADDR_LTL, l[7:0]);
   endtask : setlim

   // The flag is cleared after each sample so every result is judged on its own.
   task automatic win(input logic [15:0] v);
      h = exp_hit(v, gt, lt);
      result = v; res_valid = 1;
      @(posedge clk); #1 res_valid = 0; result = ~v;
      repeat (3) @(posedge clk);
      #1 `TB_CHK("window_irq", h, window_irq)
      rd(`ATW_ADDR_CTL, {4'h0, h, 3'h0}, "window_flag");
      wr(`ATW_ADDR_CTL, 8'h00);
   endtask : win

   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results

   initial begin
      #(20000 * 100);
      n_mismatch++;
      results();
   end

   // ---------------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      #1 rst_n = 1;
      `TB_CHK("tm_rst", 2'b11, tracking_mode)
      `TB_CHK("sar_rst", 5'd16, post_track_sar)
      rd(`ATW_ADDR_TK, `ATW_RST_TK, "tk_rst");
      rd(`ATW_ADDR_GTH, `ATW_RST_GT, "gth_rst");
      rd(`ATW_ADDR_LTL, 8'h00, "ltl_rst");
      rd(`ATW_ADDR_LTH, 8'h00, "lth_rst");
      rd(`ATW_ADDR_REF, 8'h00, "ref_rst");
      wr(8'h55, 8'ha5);
      rd(8'h55, 8'h00, "unmapped");
      $display("test reset done");

      for (int tm = 1; tm < 4; tm++) begin
         for (int tk = 0; tk < 4; tk++) begin
            d = {4'h9, tm[1:0], tk[1:0]};
            wr(`ATW_ADDR_TK, d);
            `TB_CHK("tm", tm[1:0], tracking_mode)
            `TB_CHK("sar", 5'd2 << tk, post_track_sar)
            `TB_CHK("base", 2'd`ATW_EXTRA_BASE, post_track_base)
            rd(`ATW_ADDR_TK, d, "tk_rb");
         end
      end
      $display("test tracking done");

      setlim(16'h0100, 16'h0200);
      win(16'h0100); win(16'h0101); win(16'h01ff); win(16'h0200);
      setlim(16'h0200, 16'h0100);
      win(16'h00ff); win(16'h0100); win(16'h0200); win(16'h0201);
      for (int i = 0; i < 6; i++) begin
         r = 16'($random(seed));
         setlim(16'($random(seed)), 16'($random(seed)));
         win(r);
      end
      setlim(16'h0100, 16'h0200);
      result = 16'h0000; res_valid = 1;
      @(posedge clk); #1 result = 16'h0150;
      @(posedge clk); #1 result = 16'h0300;
      @(posedge clk); #1 res_valid = 0;
      repeat (4) @(posedge clk);
      #1 result = 16'h0000; res_valid = 1;
      @(posedge clk); #1 res_valid = 0;
      repeat (4) @(posedge clk);
      #1 rd(`ATW_ADDR_CTL, 8'h08, "flag_held");
      wr(`ATW_ADDR_CTL, 8'h08);
      rd(`ATW_ADDR_CTL, 8'h08, "flag_w1");
      wr(`ATW_ADDR_CTL, 8'h00);
      rd(`ATW_ADDR_CTL, 8'h00, "flag_clr");
      // A match landing on the clearing write must leave the flag set.
      result = 16'h0150; res_valid = 1;
      @(posedge clk); #1 res_valid = 0;
      wr(`ATW_ADDR_CTL, 8'h00);
      rd(`ATW_ADDR_CTL, 8'h08, "flag_set_wins");
      $display("test window done");

      wr(`ATW_ADDR_CTL, 8'h00);
      `TB_CHK("pwr_off", 1'b0, conv_powered)
      wr(`ATW_ADDR_TK, 8'h0f);
      wr(`ATW_ADDR_CTL, 8'h80);
      @(posedge clk);
      #1 `TB_CHK("pwr_en", 1'b1, conv_powered)
      wr(`ATW_ADDR_CTL, 8'hc0);
      conv_start = 1;
      @(posedge clk); #1 conv_start = 0;
      repeat (4) @(posedge clk);
      #1 `TB_CHK("pwr_burst_en", 1'b1, conv_powered)
      for (int i = 0; i < 2; i++) begin
         lo = ((i == 0 ? 0 : 15) + 1) * `ATW_PWR_STEP_CYC;
         wr(`ATW_ADDR_TK, {(i == 0) ? 4'h0 : 4'hf, 4'hf});
         wr(`ATW_ADDR_CTL, 8'h40);
         repeat (3 * lo) @(posedge clk);
         #1 `TB_CHK("pwr_low", 1'b0, conv_powered)
         conv_start = 1;
         @(posedge clk); #1 conv_start = 0;
         // Power is sampled during the wait; it drops again as the wait ends.
         @(posedge clk);
         #1 `TB_CHK("pwr_wake", 1'b1, conv_powered)
         n = 2;
         while (conv_ready !== 1'b1 && n < 100) begin
            @(posedge clk); #1 n++;
         end
         `TB_CHK("ready_time", 1'b1, (conv_ready === 1'b1 && n >= lo && n <= lo + 4))
      end
      $display("test power done");

      for (int i = 0; i < 8; i++) begin
         d = 8'($random(seed));
         o = 1'($random(seed));
         wr(`ATW_ADDR_CTL, {d[6], 7'h00});
         wr(`ATW_ADDR_REF, {2'b00, d[5:0]});
         osc_on = o;
         repeat (2) @(posedge clk);
         b = d[1] | d[6] | d[2] | o;
         #1 `TB_CHK("ref_sel", d[3], ref_vdd_sel)
         `TB_CHK("ref_lvl", d[4], ref_high_lvl)
         `TB_CHK("temp", d[2], temp_sensor_on)
         `TB_CHK("bias", b, bias_on)
         `TB_CHK("buf", d[0], ref_buf_on)
         `TB_CHK("ztc", d[5], ztc_forced)
         rd(`ATW_ADDR_REF, {2'b00, d[5:2], b, d[0]}, "ref_rb");
      end
      $display("test reference done");
      results();
   end
endmodule : tb_top
